// ---- rtl/arw_pkg.sv ----
// Register map, field layout and constants of the converter control.
package arw_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_ENABLE_MODE   = 5'h00;
  localparam logic [4:0] OFS_ACCUM_COUNT   = 5'h01;
  localparam logic [4:0] OFS_REF_PRESCALE  = 5'h02;
  localparam logic [4:0] OFS_DELAY_CTRL    = 5'h03;
  localparam logic [4:0] OFS_WINDOW_MODE   = 5'h04;
  localparam logic [4:0] OFS_SAMPLE_LEN    = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_SEL   = 5'h06;
  localparam logic [4:0] OFS_CONV_COMMAND  = 5'h08;
  localparam logic [4:0] OFS_EVENT_CTRL    = 5'h09;
  localparam logic [4:0] OFS_IRQ_ENABLE    = 5'h0A;
  localparam logic [4:0] OFS_FLAGS         = 5'h0B;
  localparam logic [4:0] OFS_DEBUG_RUN     = 5'h0C;
  localparam logic [4:0] OFS_BYTE_BUFFER   = 5'h0D;
  localparam logic [4:0] OFS_CONV_VALUE    = 5'h10;
  localparam logic [4:0] OFS_WIN_LOW       = 5'h12;
  localparam logic [4:0] OFS_WIN_HIGH      = 5'h14;
  localparam logic [4:0] OFS_DUTY_DUTY_CALIBRATION    = 5'h16;

  // Field positions.
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_CONTINUOUS_CONVERSION_MODE   = 1;
  localparam int BIT_RES8      = 2;
  localparam int BIT_KEEP_STBY = 7;
  localparam int BIT_GO        = 0;
  localparam int BIT_INVALID   = 7;
  localparam int BIT_EVT_EN    = 0;
  localparam int BIT_DONE      = 0;
  localparam int BIT_WMATCH    = 1;

  // Write masks of the byte registers.
  localparam logic [7:0] MASK_ENABLE_MODE  = 8'h87;
  localparam logic [7:0] MASK_ACCUM_COUNT  = 8'h07;
  localparam logic [7:0] MASK_REF_PRESCALE = 8'h77;
  localparam logic [7:0] MASK_WINDOW_MODE  = 8'h07;
  localparam logic [7:0] MASK_SAMPLE_LEN   = 8'h1F;
  localparam logic [7:0] MASK_CHANNEL_SEL  = 8'h1F;
  localparam logic [7:0] MASK_ONE_BIT      = 8'h01;
  localparam logic [7:0] MASK_FLAGS        = 8'h03;

  // Reset values.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Conversion figures.
  localparam logic [9:0]  FULL_SCALE     = 10'h3FF;
  localparam logic [5:0]  CONV_BASE_CYC  = 6'h0D;
  localparam logic [2:0]  ACCUM_MAX_CODE = 3'h6;
  localparam logic [8:0]  INIT_DLY_UNIT  = 9'h010;
  localparam logic [2:0]  INIT_DLY_MAX   = 3'h5;

  // Reference choice codes.
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;

  // Window compare codes.
  localparam logic [2:0] WIN_OFF     = 3'h0;
  localparam logic [2:0] WIN_BELOW   = 3'h1;
  localparam logic [2:0] WIN_ABOVE   = 3'h2;
  localparam logic [2:0] WIN_INSIDE  = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // Interrupt vector offsets.
  localparam logic [7:0] VEC_DONE   = 8'h00;
  localparam logic [7:0] VEC_WMATCH = 8'h02;

  // Sample delivered by the analog core.
  typedef struct packed {
    logic       over_ref;
    logic [9:0] code;
  } arw_sample_s;

  // Interrupt request group.
  typedef struct packed {
    logic       done_req;
    logic       wmatch_req;
    logic       any_req;
    logic [7:0] vector;
  } arw_irq_s;

  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_CONV} arw_state_e;

endpackage : arw_pkg

// ---- rtl/arw_ctrl.sv ----
// Converter control: registers, sequencing, accumulation, window and sleep.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module arw_ctrl
  import arw_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK_IN,
  input  wire logic              NRST_IN,
  // Register port
  input  wire logic [4:0]        ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [7:0]        RDATA_OUT,
  // Event and sleep
  input  wire logic              EVENT_IN,
  input  wire logic              STANDBY_IN,
  input  wire logic              PWRDOWN_IN,
  output logic                   CLK_REQ_OUT,
  // Analog core
  input  wire arw_pkg::arw_sample_s SAMPLE_IN,
  output logic                   CONVERTING_OUT,
  output logic                   SAMPLE_TAKE_OUT,
  output logic      [1:0]        REF_SEL_OUT,
  output logic      [4:0]        CHANNEL_OUT,
  // Interrupt requests
  output arw_pkg::arw_irq_s      IRQ_OUT
);
  import arw_pkg::*;

  function automatic logic [7:0] presc_last(input logic [2:0] code);
    logic [8:0] div;
    div = 9'h002 << code;
    presc_last = 8'(div - 9'h001);
  endfunction : presc_last

  function automatic logic [6:0] accum_total(input logic [2:0] code);
    logic [2:0] c;
    c = (code > ACCUM_MAX_CODE) ? ACCUM_MAX_CODE : code;
    accum_total = 7'h01 << c;
  endfunction : accum_total

  logic [7:0]  enable_mode_r;
  logic [7:0]  accum_count_r;
  logic [7:0]  ref_prescale_r;
  logic [7:0]  delay_ctrl_r;
  logic [7:0]  window_mode_r;
  logic [7:0]  sample_len_r;
  logic [7:0]  channel_r;
  logic [7:0]  event_ctrl_r;
  logic [7:0]  irq_enable_r;
  logic [7:0]  debug_run_r;
  logic [7:0]  byte_buffer_r;
  logic [7:0]  duty_duty_calibration_r;
  logic [15:0] win_low_r;
  logic [15:0] win_high_r;
  logic [15:0] conv_value_r;
  logic        go_r;
  logic        invalid_r;
  logic        done_flag_r;
  logic        wmatch_flag_r;
  logic [7:0]  rdata_r;
  logic        ev_s1_r;
  logic        ev_s2_r;
  logic        ev_s3_r;
  logic        ev_level_r;
  logic        ev_edge;
  arw_state_e  state_r;
  logic [7:0]  presc_r;
  logic        adc_tick;
  logic [8:0]  cyc_r;
  logic [6:0]  samp_cnt_r;
  logic [15:0] accum_r;
  logic        need_init_r;
  logic        halted_r;
  logic        resumed_r;
  logic        enabled_q_r;
  logic        stby_q_r;
  logic [1:0]  ref_lock_r;
  logic [4:0]  chan_lock_r;
  logic        sample_take_r;
  logic        clk_req_r;
  arw_irq_s    irq_r;
  logic        enabled;
  logic        halt;
  logic        wr_go;
  logic        start_req;
  logic        sample_end;
  logic        last_sample;
  logic [9:0]  sample_code;
  logic [15:0] sample_val;
  logic [15:0] final_sum;
  logic        win_hit;
  logic        conv_done;
  logic [5:0]  conv_last;
  logic [8:0]  init_last;
  logic        rd_value;

  assign enabled = enable_mode_r[BIT_ENABLE];
  // Standby without keep-active freezes like power-down.
  assign halt = PWRDOWN_IN | (STANDBY_IN & ~enable_mode_r[BIT_KEEP_STBY]);
  assign wr_go = WR_IN & (ADDR_IN == OFS_CONV_COMMAND) & WDATA_IN[BIT_GO];
  // An enabled event starts a conversion on its edge.
  assign start_req = enabled & ~halt & ~go_r &
                     (wr_go | (event_ctrl_r[BIT_EVT_EN] & ev_edge));
  assign conv_last = CONV_BASE_CYC + {2'h0, delay_ctrl_r[3:0]} +
                     {1'h0, sample_len_r[4:0]};
  assign init_last = (delay_ctrl_r[7:5] > INIT_DLY_MAX) ? 9'h000 :
                     9'(INIT_DLY_UNIT << (delay_ctrl_r[7:5] - 3'h1));
  assign sample_end = (state_r == ST_CONV) & adc_tick & ~halt &
                      (cyc_r == {3'h0, conv_last} - 9'h001);
  assign last_sample = samp_cnt_r == accum_total(accum_count_r[2:0]) - 7'h01;
  // Inputs at or over the reference clamp to full scale.
  assign sample_code = SAMPLE_IN.over_ref ? FULL_SCALE : SAMPLE_IN.code;
  assign sample_val = enable_mode_r[BIT_RES8] ?
                      {8'h00, sample_code[9:2]} : {6'h00, sample_code};
  assign final_sum = accum_r + sample_val;
  assign conv_done = sample_end & last_sample;
  assign rd_value = RD_IN & (ADDR_IN == OFS_CONV_VALUE);

  // Strict window test on the full 16-bit sum, only at the final sample.
  always_comb
  begin
    unique case (window_mode_r[2:0])
      WIN_BELOW:   win_hit = final_sum < win_low_r;
      WIN_ABOVE:   win_hit = final_sum > win_high_r;
      WIN_INSIDE:  win_hit = (final_sum > win_low_r) &
                             (final_sum < win_high_r);
      WIN_OUTSIDE: win_hit = (final_sum < win_low_r) |
                             (final_sum > win_high_r);
      default:     win_hit = 1'b0;
    endcase
  end

  // Three-stage event sync; a change counts once stages two and three agree.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      ev_s1_r    <= 1'b0;
      ev_s2_r    <= 1'b0;
      ev_s3_r    <= 1'b0;
      ev_level_r <= 1'b0;
    end
    else
    begin
      ev_s1_r <= EVENT_IN;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      if (ev_s2_r == ev_s3_r)
        ev_level_r <= ev_s3_r;
    end
  end
  assign ev_edge = ev_s2_r & ev_s3_r & ~ev_level_r;

  // Prescaler runs only during a conversion so the start delay is fixed.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      presc_r <= 8'h00;
    else if (state_r == ST_IDLE || !enabled)
      presc_r <= 8'h00;
    else if (!halt)
      presc_r <= adc_tick ? 8'h00 : presc_r + 8'h01;
  end
  assign adc_tick = presc_r == presc_last(ref_prescale_r[2:0]);

  // Sequencer.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      state_r    <= ST_IDLE;
      cyc_r      <= 9'h000;
      samp_cnt_r <= 7'h00;
      accum_r    <= RST_WORD;
    end
    else if (!enabled)
      state_r <= ST_IDLE;
    else if (!halt)
    begin
      unique case (state_r)
        ST_IDLE:
          if (start_req)
          begin
            cyc_r      <= 9'h000;
            samp_cnt_r <= 7'h00;
            accum_r    <= RST_WORD;
            state_r    <= (need_init_r && init_last != 9'h000) ?
                          ST_INIT : ST_CONV;
          end
        ST_INIT:
          if (adc_tick)
          begin
            cyc_r <= cyc_r + 9'h001;
            if (cyc_r == init_last - 9'h001)
            begin
              cyc_r   <= 9'h000;
              state_r <= ST_CONV;
            end
          end
        ST_CONV:
          if (sample_end)
          begin
            cyc_r <= 9'h000;
            // Only the final accumulated sum is compared.
            if (last_sample)
            begin
              samp_cnt_r <= 7'h00;
              accum_r    <= RST_WORD;
              // Free-running restarts at once while the go bit stays.
              if (!enable_mode_r[BIT_CONTINUOUS_CONVERSION_MODE])
                state_r <= ST_IDLE;
            end
            else
            begin
              samp_cnt_r <= samp_cnt_r + 7'h01;
              accum_r    <= final_sum;
            end
          end
          else if (adc_tick)
            cyc_r <= cyc_r + 9'h001;
      endcase
    end
  end

  // Startup wait is owed after enabling and after entering standby.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      need_init_r <= 1'b1;
      enabled_q_r <= 1'b0;
      stby_q_r    <= 1'b0;
    end
    else
    begin
      enabled_q_r <= enabled;
      stby_q_r    <= STANDBY_IN;
      if ((enabled && !enabled_q_r) || (STANDBY_IN && !stby_q_r))
        need_init_r <= 1'b1;
      else if (state_r == ST_INIT && !halt)
        need_init_r <= 1'b0;
    end
  end

  // Halting mid-conversion taints the result of that conversion.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      halted_r  <= 1'b0;
      resumed_r <= 1'b0;
      invalid_r <= 1'b0;
    end
    else
    begin
      halted_r <= halt & (state_r != ST_IDLE);
      if (halted_r && !halt)
        resumed_r <= 1'b1;
      else if (conv_done || state_r == ST_IDLE)
        resumed_r <= 1'b0;
      if (conv_done)
        invalid_r <= resumed_r | halt;
    end
  end

  // Go bit, flags and result.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      go_r          <= 1'b0;
      done_flag_r   <= 1'b0;
      wmatch_flag_r <= 1'b0;
      conv_value_r  <= RST_WORD;
    end
    else
    begin
      if (!enabled)
        go_r <= 1'b0;
      else if (start_req)
        go_r <= 1'b1;
      else if (conv_done && !enable_mode_r[BIT_CONTINUOUS_CONVERSION_MODE])
        go_r <= 1'b0;
      if (conv_done)
        conv_value_r <= final_sum;
      // Hardware set wins over a clear in the same cycle.
      if (conv_done)
        done_flag_r <= 1'b1;
      else if (rd_value ||
               (WR_IN && ADDR_IN == OFS_FLAGS && WDATA_IN[BIT_DONE]))
        done_flag_r <= 1'b0;
      if (conv_done && win_hit)
        wmatch_flag_r <= 1'b1;
      else if (WR_IN && ADDR_IN == OFS_FLAGS && WDATA_IN[BIT_WMATCH])
        wmatch_flag_r <= 1'b0;
    end
  end

  // Software registers.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      enable_mode_r  <= RST_BYTE;
      accum_count_r  <= RST_BYTE;
      ref_prescale_r <= RST_BYTE;
      delay_ctrl_r   <= RST_BYTE;
      window_mode_r  <= RST_BYTE;
      sample_len_r   <= RST_BYTE;
      channel_r      <= RST_BYTE;
      event_ctrl_r   <= RST_BYTE;
      irq_enable_r   <= RST_BYTE;
      debug_run_r    <= RST_BYTE;
      byte_buffer_r  <= RST_BYTE;
      duty_duty_calibration_r   <= RST_BYTE;
      win_low_r      <= RST_WORD;
      win_high_r     <= RST_WORD;
    end
    else if (WR_IN)
    begin
      unique case (ADDR_IN)
        OFS_ENABLE_MODE:  enable_mode_r  <= WDATA_IN & MASK_ENABLE_MODE;
        OFS_ACCUM_COUNT:  accum_count_r  <= WDATA_IN & MASK_ACCUM_COUNT;
        OFS_REF_PRESCALE: ref_prescale_r <= WDATA_IN & MASK_REF_PRESCALE;
        OFS_DELAY_CTRL:   delay_ctrl_r   <= WDATA_IN;
        OFS_WINDOW_MODE:  window_mode_r  <= WDATA_IN & MASK_WINDOW_MODE;
        OFS_SAMPLE_LEN:   sample_len_r   <= WDATA_IN & MASK_SAMPLE_LEN;
        OFS_CHANNEL_SEL:  channel_r      <= WDATA_IN & MASK_CHANNEL_SEL;
        OFS_EVENT_CTRL:   event_ctrl_r   <= WDATA_IN & MASK_ONE_BIT;
        OFS_IRQ_ENABLE:   irq_enable_r   <= WDATA_IN & MASK_FLAGS;
        OFS_DEBUG_RUN:    debug_run_r    <= WDATA_IN & MASK_ONE_BIT;
        OFS_BYTE_BUFFER:  byte_buffer_r  <= WDATA_IN;
        OFS_DUTY_DUTY_CALIBRATION:   duty_duty_calibration_r   <= WDATA_IN & MASK_ONE_BIT;
        OFS_WIN_LOW:      win_low_r[7:0]   <= WDATA_IN;
        OFS_WIN_LOW + 5'h01:  win_low_r[15:8]  <= WDATA_IN;
        OFS_WIN_HIGH:     win_high_r[7:0]  <= WDATA_IN;
        OFS_WIN_HIGH + 5'h01: win_high_r[15:8] <= WDATA_IN;
        default: ;
      endcase
    end
  end

  // Read port: data stand only in the cycle after the strobe.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      rdata_r <= RST_BYTE;
    else if (!RD_IN)
      rdata_r <= RST_BYTE;
    else
    begin
      unique case (ADDR_IN)
        OFS_ENABLE_MODE:  rdata_r <= enable_mode_r;
        OFS_ACCUM_COUNT:  rdata_r <= accum_count_r;
        OFS_REF_PRESCALE: rdata_r <= ref_prescale_r;
        OFS_DELAY_CTRL:   rdata_r <= delay_ctrl_r;
        OFS_WINDOW_MODE:  rdata_r <= window_mode_r;
        OFS_SAMPLE_LEN:   rdata_r <= sample_len_r;
        OFS_CHANNEL_SEL:  rdata_r <= channel_r;
        OFS_CONV_COMMAND: rdata_r <= {invalid_r, 6'h00, go_r};
        OFS_EVENT_CTRL:   rdata_r <= event_ctrl_r;
        OFS_IRQ_ENABLE:   rdata_r <= irq_enable_r;
        OFS_FLAGS:        rdata_r <= {6'h00, wmatch_flag_r, done_flag_r};
        OFS_DEBUG_RUN:    rdata_r <= debug_run_r;
        OFS_BYTE_BUFFER:  rdata_r <= byte_buffer_r;
        OFS_DUTY_DUTY_CALIBRATION:   rdata_r <= duty_duty_calibration_r;
        OFS_CONV_VALUE:   rdata_r <= conv_value_r[7:0];
        OFS_CONV_VALUE + 5'h01: rdata_r <= conv_value_r[15:8];
        OFS_WIN_LOW:      rdata_r <= win_low_r[7:0];
        OFS_WIN_LOW + 5'h01:    rdata_r <= win_low_r[15:8];
        OFS_WIN_HIGH:     rdata_r <= win_high_r[7:0];
        OFS_WIN_HIGH + 5'h01:   rdata_r <= win_high_r[15:8];
        default:          rdata_r <= RST_BYTE;
      endcase
    end
  end

  // Reference and channel follow software while no conversion runs and reload at the end of each conversion.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      ref_lock_r  <= REF_INTERNAL;
      chan_lock_r <= 5'h00;
    end
    else if (state_r == ST_IDLE || conv_done)
    begin
      ref_lock_r  <= ref_prescale_r[5:4];
      chan_lock_r <= channel_r[4:0];
    end
  end

  // Analog strobes, clock request and interrupt requests.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      sample_take_r <= 1'b0;
      clk_req_r     <= 1'b0;
      irq_r         <= '0;
    end
    else
    begin
      sample_take_r <= sample_end;
      // The clock is held in standby while work is owed.
      clk_req_r <= STANDBY_IN & ~halt & (start_req | (state_r != ST_IDLE));
      irq_r.done_req   <= done_flag_r & irq_enable_r[BIT_DONE];
      irq_r.wmatch_req <= wmatch_flag_r & irq_enable_r[BIT_WMATCH];
      irq_r.any_req    <= (done_flag_r & irq_enable_r[BIT_DONE]) |
                          (wmatch_flag_r & irq_enable_r[BIT_WMATCH]);
      irq_r.vector     <= (done_flag_r & irq_enable_r[BIT_DONE]) ?
                          VEC_DONE : VEC_WMATCH;
    end
  end

  assign RDATA_OUT       = rdata_r;
  assign CLK_REQ_OUT     = clk_req_r;
  assign CONVERTING_OUT  = go_r;
  assign SAMPLE_TAKE_OUT = sample_take_r;
  assign REF_SEL_OUT     = ref_lock_r;
  assign CHANNEL_OUT     = chan_lock_r;
  assign IRQ_OUT         = irq_r;

endmodule : arw_ctrl

// ---- test/arw_core_model.sv ----
// Behavioural analog sampling core facing the converter control.
`timescale 1ns/100ps
module arw_core_model
  import arw_pkg::*;
(
  // Control side
  input  wire logic            converting_in,
  // Stimulus
  input  wire logic [9:0]      level_in,
  input  wire logic            over_in,
  // Sample
  output arw_pkg::arw_sample_s sample_out
);
  // The core keeps no output between conversions, so it shows junk there.
  // One assignment drives the whole struct.
  assign sample_out = converting_in ? {over_in, level_in} :
                                      ~{over_in, level_in};
endmodule : arw_core_model

// ---- test/arw_ctrl_asserts.sv ----
// Port checks of the converter control.
`timescale 1ns/100ps
module arw_ctrl_asserts
  import arw_pkg::*;
(
  // Clock, reset, register port
  input wire logic             MCLK_IN,
  input wire logic             NRST_IN,
  input wire logic [4:0]       ADDR_IN,
  input wire logic [7:0]       WDATA_IN,
  input wire logic             WR_IN,
  input wire logic             RD_IN,
  input wire logic [7:0]       RDATA_OUT,
  // Sleep and core
  input wire logic             STANDBY_IN,
  input wire logic             PWRDOWN_IN,
  input wire logic             CONVERTING_OUT,
  input wire logic             SAMPLE_TAKE_OUT,
  input wire arw_pkg::arw_irq_s IRQ_OUT
);
  import arw_pkg::*;
  logic en_r;
  logic keep_r;
  logic clr_c;
  // Shadow of the enable bits, taken at the same edge as the design.
  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      en_r   <= 1'b0;
      keep_r <= 1'b0;
    end
    else if (WR_IN && ADDR_IN == OFS_ENABLE_MODE)
    begin
      en_r   <= WDATA_IN[BIT_ENABLE];
      keep_r <= WDATA_IN[BIT_KEEP_STBY];
    end
  end
  assign clr_c = (WR_IN && ADDR_IN == OFS_FLAGS && WDATA_IN[BIT_DONE])
    || (RD_IN && ADDR_IN == OFS_CONV_VALUE)
    || (WR_IN && ADDR_IN == OFS_IRQ_ENABLE);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside its cycle");
  a_irq_any: assert property (IRQ_OUT.any_req ==
    (IRQ_OUT.done_req || IRQ_OUT.wmatch_req)) else $error("any request");
  a_vec_select: assert property (IRQ_OUT.any_req |->
    IRQ_OUT.vector == (IRQ_OUT.done_req ? VEC_DONE : VEC_WMATCH))
    else $error("vector offset");
  a_take_conv: assert property (SAMPLE_TAKE_OUT |->
    $past(CONVERTING_OUT)) else $error("sample outside conversion");
  a_pd_freeze: assert property (PWRDOWN_IN [*3] |->
    !SAMPLE_TAKE_OUT) else $error("sample in power-down");
  a_pd_nostart: assert property (PWRDOWN_IN && !CONVERTING_OUT |=>
    !CONVERTING_OUT) else $error("start in power-down");
  a_stby_idle: assert property (STANDBY_IN && !keep_r &&
    !CONVERTING_OUT |=> !CONVERTING_OUT) else $error("start in standby");
  a_go_start: assert property (WR_IN && ADDR_IN == OFS_CONV_COMMAND
    && WDATA_IN[BIT_GO] && en_r && !PWRDOWN_IN && !CONVERTING_OUT
    && (!STANDBY_IN || keep_r) |=> CONVERTING_OUT) else $error("no start");
  a_irq_hold: assert property ($fell(IRQ_OUT.done_req) |->
    $past(clr_c) || $past(clr_c, 2) || $past(clr_c, 3))
    else $error("request dropped without clear");
  cv_take: cover property (SAMPLE_TAKE_OUT);
  cv_wm: cover property (IRQ_OUT.wmatch_req && !IRQ_OUT.done_req);
  cv_pd: cover property (PWRDOWN_IN && CONVERTING_OUT);
endmodule : arw_ctrl_asserts
bind arw_ctrl arw_ctrl_asserts chk_u (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .STANDBY_IN(STANDBY_IN), .PWRDOWN_IN(PWRDOWN_IN),
  .CONVERTING_OUT(CONVERTING_OUT), .SAMPLE_TAKE_OUT(SAMPLE_TAKE_OUT),
  .IRQ_OUT(IRQ_OUT));

// ---- test/tb_top.sv ----
// Self-checking bench of the converter control.
`timescale 1ns/100ps
module tb_top;
  import arw_pkg::*;
  logic        MCLK_IN = 1'b0;
  logic        NRST_IN = 1'b0;
  logic [4:0]  ADDR_IN = 5'h00;
  logic [7:0]  WDATA_IN = 8'h00;
  logic        WR_IN = 1'b0;
  logic        RD_IN = 1'b0;
  logic        EVENT_IN = 1'b0;
  logic        STANDBY_IN = 1'b0;
  logic        PWRDOWN_IN = 1'b0;
  logic [9:0]  level = 10'h000;
  logic        over = 1'b0;
  logic [7:0]  RDATA_OUT;
  logic        CLK_REQ_OUT;
  logic        CONVERTING_OUT;
  logic        SAMPLE_TAKE_OUT;
  logic [1:0]  REF_SEL_OUT;
  logic [4:0]  CHANNEL_OUT;
  arw_sample_s SAMPLE_IN;
  arw_irq_s    IRQ_OUT;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_take = 0;
  logic [4:0]  ofs [6] = '{OFS_ENABLE_MODE, OFS_ACCUM_COUNT, OFS_WINDOW_MODE,
                           OFS_CONV_COMMAND, OFS_FLAGS, OFS_CONV_VALUE};
  logic [9:0]  lv [5] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300};

  always #12.5 MCLK_IN = ~MCLK_IN;
  always @(posedge MCLK_IN)
  begin
    if (SAMPLE_TAKE_OUT)
      n_take++;
  end

  arw_ctrl dut_u (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .EVENT_IN(EVENT_IN), .STANDBY_IN(STANDBY_IN), .PWRDOWN_IN(PWRDOWN_IN),
    .CLK_REQ_OUT(CLK_REQ_OUT), .SAMPLE_IN(SAMPLE_IN),
    .CONVERTING_OUT(CONVERTING_OUT), .SAMPLE_TAKE_OUT(SAMPLE_TAKE_OUT),
    .REF_SEL_OUT(REF_SEL_OUT), .CHANNEL_OUT(CHANNEL_OUT), .IRQ_OUT(IRQ_OUT));
  arw_core_model core_u (.converting_in(CONVERTING_OUT), .level_in(level),
    .over_in(over), .sample_out(SAMPLE_IN));

  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge MCLK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge MCLK_IN);
    WR_IN    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    @(posedge MCLK_IN);
    RD_IN   <= 1'b0;
    #1 d = RDATA_OUT;
  endtask : rd

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rc

  task automatic res(input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(OFS_CONV_VALUE, lo);
    rd(OFS_CONV_VALUE + 5'h01, hi);
    chk({hi, lo}, e);
  endtask : res

  // Bounded wait; a hang ends the run as a failure.
  task automatic wconv(input logic v);
    int i;
    i = 0;
    while (CONVERTING_OUT !== v && i < 5000)
    begin
      @(posedge MCLK_IN);
      #1 i++;
    end
    if (i == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : wconv

  task automatic conv(input logic [9:0] l, input logic o);
    level <= l;
    over  <= o;
    wr(OFS_CONV_COMMAND, 8'h01);
    #1 wconv(1'b0);
  endtask : conv

  task automatic evt();
    @(posedge MCLK_IN);
    EVENT_IN <= 1'b1;
    repeat (8) @(posedge MCLK_IN);
    EVENT_IN <= 1'b0;
    #1;
  endtask : evt

  function automatic logic wexp(input logic [2:0] m, input logic [15:0] r);
    case (m)
      WIN_BELOW:   return r < 16'h0100;
      WIN_ABOVE:   return r > 16'h0200;
      WIN_INSIDE:  return r > 16'h0100 && r < 16'h0200;
      WIN_OUTSIDE: return r < 16'h0100 || r > 16'h0200;
      default:     return 1'b0;
    endcase
  endfunction : wexp

  initial
  begin
    logic wm;
    repeat (4) @(posedge MCLK_IN);
    NRST_IN <= 1'b1;
    foreach (ofs[i]) rc(ofs[i], 8'h00);
    wr(OFS_WINDOW_MODE, 8'hFF);
    rc(OFS_WINDOW_MODE, MASK_WINDOW_MODE);
    wr(5'h07, 8'hFF);
    rc(5'h07, 8'h00);
    wr(OFS_CHANNEL_SEL, 8'h05);
    wr(OFS_REF_PRESCALE, 8'h10);
    wr(OFS_ENABLE_MODE, 8'h01);
    #1 chk({9'h000, CHANNEL_OUT, REF_SEL_OUT},
           {9'h000, 5'h05, REF_SUPPLY});
    wr(OFS_IRQ_ENABLE, 8'h03);
    wr(OFS_WIN_LOW + 5'h01, 8'h01);
    wr(OFS_WIN_HIGH + 5'h01, 8'h02);
    for (int m = 1; m < 5; m++)
    begin
      foreach (lv[j])
      begin
        wr(OFS_WINDOW_MODE, 8'(m));
        conv(lv[j], 1'b0);
        wm = wexp(3'(m), {6'h00, lv[j]});
        rc(OFS_FLAGS, {6'h00, wm, 1'b1});
        chk({8'h00, IRQ_OUT.vector}, {8'h00, VEC_DONE});
        res({6'h00, lv[j]});
        chk({14'h0, IRQ_OUT.done_req, IRQ_OUT.wmatch_req},
            {15'h0, wm});
        wr(OFS_FLAGS, 8'h03);
        rc(OFS_FLAGS, 8'h00);
      end
    end
    wr(OFS_WINDOW_MODE, {5'h00, WIN_OFF});
    conv(10'h050, 1'b1);
    wr(OFS_FLAGS, 8'h01);
    rc(OFS_FLAGS, 8'h00);
    res({6'h00, FULL_SCALE});
    wr(OFS_ENABLE_MODE, 8'h05);
    conv(10'h2C4, 1'b0);
    res(16'h00B1);
    wr(OFS_ENABLE_MODE, 8'h01);
    wr(OFS_ACCUM_COUNT, 8'h02);
    wr(OFS_WINDOW_MODE, {5'h00, WIN_ABOVE});
    n_take = 0;
    conv(10'h100, 1'b0);
    rc(OFS_FLAGS, 8'h03);
    chk(16'(n_take), 16'h0004);
    res(16'h0400);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_ACCUM_COUNT, 8'h00);
    wr(OFS_WINDOW_MODE, 8'h00);
    wr(OFS_EVENT_CTRL, 8'h01);
    evt();
    chk({15'h0, CONVERTING_OUT}, 16'h0001);
    wconv(1'b0);
    rc(OFS_FLAGS, 8'h01);
    STANDBY_IN <= 1'b1;
    evt();
    chk({15'h0, CONVERTING_OUT}, 16'h0000);
    wr(OFS_DELAY_CTRL, 8'h20);
    wr(OFS_ENABLE_MODE, 8'h81);
    n_take = 0;
    evt();
    chk({14'h0, CONVERTING_OUT, CLK_REQ_OUT}, 16'h0003);
    repeat (40) @(posedge MCLK_IN);
    #1 chk(16'(n_take), 16'h0000);
    wconv(1'b0);
    repeat (3) @(posedge MCLK_IN);
    #1 chk({15'h0, CLK_REQ_OUT}, 16'h0000);
    STANDBY_IN <= 1'b0;
    wr(OFS_FLAGS, 8'h03);
    PWRDOWN_IN <= 1'b1;
    wr(OFS_CONV_COMMAND, 8'h01);
    #1 chk({15'h0, CONVERTING_OUT}, 16'h0000);
    PWRDOWN_IN <= 1'b0;
    wr(OFS_CONV_COMMAND, 8'h01);
    repeat (5) @(posedge MCLK_IN);
    PWRDOWN_IN <= 1'b1;
    n_take = 0;
    repeat (200) @(posedge MCLK_IN);
    #1 chk({15'h0, CONVERTING_OUT}, 16'h0001);
    chk(16'(n_take), 16'h0000);
    PWRDOWN_IN <= 1'b0;
    wconv(1'b0);
    rc(OFS_FLAGS, 8'h01);
    rc(OFS_CONV_COMMAND, 8'h80);
    wr(OFS_ENABLE_MODE, 8'h03);
    n_take = 0;
    wr(OFS_CONV_COMMAND, 8'h01);
    repeat (60) @(posedge MCLK_IN);
    #1 chk({14'h0, CONVERTING_OUT, n_take >= 2}, 16'h0003);
    wr(OFS_ENABLE_MODE, 8'h01);
    wconv(1'b0);
    print_verdict();
  end
endmodule : tb_top
